//--- src/strap_config_latch.sv
// Purpose: Strap capture at reset release, settings registers and RMII dibit transfer
// Assumes: aclk is the RMII reference timing for this model; straps are asynchronous pins
// Notes: Strap pads are input during reset and driven from the pin-out register afterwards
//
// How it works
// R1 - Each running, non-isolated cycle with data valid high, two received bits go out on rxd.
// R2 - Each running, non-isolated cycle the MAC raises tx enable, two bits are taken from txd.
// R3 - Strap pins are sampled once at reset release and form the initial settings.
// R4 - Strap pads are inputs during reset and become driven outputs afterwards.
// R5 - Three address straps set station address low bits, 0 to 7.
// R6 - Upper two station address bits reset to 00.
// R7 - Address 0 is broadcast unless software sets special bit 9.
// R8 - Address-zero strap pulled up makes address 0 unique at reset release.
// R9 - Interface-select code 000 is RMII, 110 back-to-back, others reserved.
// R10 - Isolate strap loads control bit 10 at reset release.
// R11 - Rate strap loads control bit 13 and the advertised speed capability.
// R12 - Duplex strap loads control bit 8; pull-up means half duplex.
// R13 - Negotiation strap loads control bit 12; pull-up enables it.
// R14 - Gate-chain test strap captured at release; pull-down enables test mode.
// R15 - Captured strap values hold until next reset; only registers may change.
`include "strap_config_params.svh"
`timescale 1ns/100ps
`default_nettype none

module strap_config_latch #(
  parameter int COUNT_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite slave
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Strap pads, three signals each
  input wire logic [`SC_STRAP_PINS-1:0] strap_pad_in,
  output logic [`SC_STRAP_PINS-1:0] strap_pad_out,
  output logic [`SC_STRAP_PINS-1:0] strap_pad_oe_n,
  // Management address check
  input wire logic [4:0] mgmt_addr,
  output logic mgmt_addr_hit,
  // Configuration outputs
  output logic [4:0] station_address,
  output logic [2:0] interface_mode,
  output logic interface_mode_reserved,
  output logic test_mode_en,
  output logic [15:0] control_word,
  // Receive path: internal recovered data in, RMII out
  input wire logic rx_data_valid,
  input wire logic [1:0] rx_data,
  output logic rmii_crs_dv,
  output logic [1:0] rmii_rxd,
  // Transmit path: RMII in, internal data out
  input wire logic rmii_tx_en,
  input wire logic [1:0] rmii_txd,
  output logic tx_data_valid,
  output logic [1:0] tx_data
);

  // Merge byte lanes of a write into a stored word
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_val, input logic [31:0] new_val,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[i*8 +: 8] = new_val[i*8 +: 8];
    end
    return res;
  endfunction

  // True for any interface-select code that is not defined
  function automatic logic mode_reserved(input logic [2:0] code);
    return (code != `SC_MODE_RMII) && (code != `SC_MODE_B2B);
  endfunction

  logic [`SC_STRAP_PINS-1:0] strap_sync1_reg;
  logic [`SC_STRAP_PINS-1:0] strap_sync2_reg;
  strap_config_pkg::cap_state_t state_reg;
  strap_config_pkg::strap_image_t strap_reg;
  strap_config_pkg::strap_image_t strap_next;
  logic [15:0] control_reg;
  logic speed_cap_100_reg;
  logic addr0_unique_reg;
  logic [`SC_STRAP_PINS-1:0] pinout_reg;
  logic [COUNT_W-1:0] rx_count_reg;
  logic [COUNT_W-1:0] tx_count_reg;
  logic [5:0] aw_addr_reg;
  logic aw_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_held_reg;
  logic wr_fire;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;
  logic [31:0] wr_merged;
  logic [31:0] control_word32;
  logic [31:0] advert_word;

  // Two-flop synchroniser on the strap pads; runs during reset so data is ready at release
  always_ff @(posedge aclk) begin
    if (ce) begin
      strap_sync1_reg <= strap_pad_in;
      strap_sync2_reg <= strap_sync1_reg;
    end
  end

  // Decode the synchronised pad levels into a strap image
  always_comb begin
    strap_next.addr_lo = strap_sync2_reg[`SC_PIN_ADDR_LO +: 3]; // R5
    strap_next.mode = strap_sync2_reg[`SC_PIN_MODE_LO +: 3]; // R9
    strap_next.isolate = strap_sync2_reg[`SC_PIN_ISOLATE]; // R10
    strap_next.speed_100 = strap_sync2_reg[`SC_PIN_SPEED]; // R11
    strap_next.duplex_full = ~strap_sync2_reg[`SC_PIN_DUPLEX]; // R12
    strap_next.autoneg_en = strap_sync2_reg[`SC_PIN_AUTONEG]; // R13
    strap_next.addr0_unique = strap_sync2_reg[`SC_PIN_ADDR0_UNIQUE]; // R8
    strap_next.test_mode_en = ~strap_sync2_reg[`SC_PIN_TEST_N]; // R14
  end

  // Capture sequence: one capture at the first enabled edge after reset release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= strap_config_pkg::ST_CAPTURE;
    end else if (ce) begin
      case (state_reg)
        strap_config_pkg::ST_CAPTURE: state_reg <= strap_config_pkg::ST_RUN; // R3
        strap_config_pkg::ST_RUN: state_reg <= strap_config_pkg::ST_RUN; // R15
        default: state_reg <= strap_config_pkg::ST_CAPTURE;
      endcase
    end
  end

  // Latched strap image, untouched by software until the next reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_reg <= '0;
    end else if (ce && state_reg == strap_config_pkg::ST_CAPTURE) begin
      strap_reg <= strap_next; // R3 R15
    end
  end

  // Pad direction: inputs through reset and capture, driven afterwards
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_pad_oe_n <= '1; // R4
      strap_pad_out <= '0;
    end else if (ce) begin
      strap_pad_oe_n <= (state_reg == strap_config_pkg::ST_RUN) ? '0 : '1; // R4
      strap_pad_out <= pinout_reg;
    end
  end

  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign control_word32 = {16'h0000, control_reg};
  assign advert_word = {23'h000000, speed_cap_100_reg, speed_cap_100_reg, 1'b1, 1'b1, 5'h01};

  // Settings registers: strap loads at capture, software writes afterwards
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_reg <= '0;
      speed_cap_100_reg <= 1'b0;
      addr0_unique_reg <= 1'b0; // R7
    end else if (ce) begin
      if (state_reg == strap_config_pkg::ST_CAPTURE) begin
        control_reg <= '0;
        control_reg[`SC_CTL_ISOLATE] <= strap_next.isolate; // R10
        control_reg[`SC_CTL_SPEED] <= strap_next.speed_100; // R11
        control_reg[`SC_CTL_DUPLEX] <= strap_next.duplex_full; // R12
        control_reg[`SC_CTL_AUTONEG] <= strap_next.autoneg_en; // R13
        speed_cap_100_reg <= strap_next.speed_100; // R11
        addr0_unique_reg <= strap_next.addr0_unique; // R8
      end else if (wr_fire && aw_addr_reg == `SC_OFS_CONTROL) begin
        control_reg <= wr_merged[15:0]; // R15
      end else if (wr_fire && aw_addr_reg == `SC_OFS_ADVERT) begin
        speed_cap_100_reg <= wr_merged[`SC_ADV_100_HALF];
      end else if (wr_fire && aw_addr_reg == `SC_OFS_SPECIAL) begin
        addr0_unique_reg <= wr_merged[`SC_SPC_ADDR0_UNIQUE]; // R7
      end
    end
  end

  // Pad drive values once the straps become outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pinout_reg <= '0;
    end else if (ce && wr_fire && aw_addr_reg == `SC_OFS_PINOUT) begin
      pinout_reg <= wr_merged[`SC_STRAP_PINS-1:0];
    end
  end

  // Configuration outputs held from the latched image and the settings registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      station_address <= '0;
      interface_mode <= '0;
      interface_mode_reserved <= 1'b0;
      test_mode_en <= 1'b0;
      control_word <= '0;
      mgmt_addr_hit <= 1'b0;
    end else if (ce) begin
      station_address <= {`SC_ADDR_UPPER_RESET, strap_reg.addr_lo}; // R5 R6
      interface_mode <= strap_reg.mode; // R9
      interface_mode_reserved <= mode_reserved(strap_reg.mode); // R9
      test_mode_en <= strap_reg.test_mode_en; // R14
      control_word <= control_reg;
      // Address 0 answers as broadcast unless the unique bit, loaded from the strap or last written by software, is set
      mgmt_addr_hit <= (state_reg == strap_config_pkg::ST_RUN) &&
                       ((mgmt_addr == {`SC_ADDR_UPPER_RESET, strap_reg.addr_lo}) ||
                        (mgmt_addr == 5'h00 && !addr0_unique_reg)); // R7 R8
    end
  end

  // Receive direction: one dibit to the MAC per valid cycle, silent while isolated
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rmii_crs_dv <= 1'b0;
      rmii_rxd <= 2'h0;
      rx_count_reg <= '0;
    end else if (ce) begin
      if (rx_data_valid && !control_reg[`SC_CTL_ISOLATE] && state_reg == strap_config_pkg::ST_RUN) begin
        rmii_crs_dv <= 1'b1; // R1
        rmii_rxd <= rx_data; // R1
        rx_count_reg <= rx_count_reg + 1'b1;
      end else begin
        rmii_crs_dv <= 1'b0;
        rmii_rxd <= 2'h0;
      end
    end
  end

  // Transmit direction: one dibit taken per tx enable cycle, ignored while isolated
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_data_valid <= 1'b0;
      tx_data <= 2'h0;
      tx_count_reg <= '0;
    end else if (ce) begin
      if (rmii_tx_en && !control_reg[`SC_CTL_ISOLATE] && state_reg == strap_config_pkg::ST_RUN) begin
        tx_data_valid <= 1'b1; // R2
        tx_data <= rmii_txd; // R2
        tx_count_reg <= tx_count_reg + 1'b1;
      end else begin
        tx_data_valid <= 1'b0;
        tx_data <= 2'h0;
      end
    end
  end

  // Write address channel: hold one address until the response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (ce) begin
      if (s_axi_awready && s_axi_awvalid) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[5:2], 2'b00};
        s_axi_awready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        aw_held_reg <= 1'b0;
        s_axi_awready <= 1'b1;
      end else begin
        s_axi_awready <= !aw_held_reg;
      end
    end
  end

  // Write data channel, independent of the address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (ce) begin
      if (s_axi_wready && s_axi_wvalid) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        w_held_reg <= 1'b0;
        s_axi_wready <= 1'b1;
      end else begin
        s_axi_wready <= !w_held_reg;
      end
    end
  end

  // Writable offsets and the word a write leaves there, byte lanes merged into the stored value
  always_comb begin
    wr_hit = 1'b1;
    wr_merged = 32'h00000000;
    case (aw_addr_reg)
      `SC_OFS_CONTROL: wr_merged = merge_bytes(control_word32, w_data_reg, w_strb_reg);
      `SC_OFS_ADVERT: wr_merged = merge_bytes(advert_word, w_data_reg, w_strb_reg);
      `SC_OFS_SPECIAL: wr_merged = merge_bytes({22'h0, addr0_unique_reg, 9'h0}, w_data_reg, w_strb_reg);
      `SC_OFS_PINOUT: wr_merged = merge_bytes({20'h0, pinout_reg}, w_data_reg, w_strb_reg);
      default: wr_hit = 1'b0;
    endcase
  end

  // Write response once both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SC_RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `SC_RESP_OKAY : `SC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read decode; unmapped offsets read zero with an error response
  always_comb begin
    rd_hit = 1'b1;
    case ({s_axi_araddr[5:2], 2'b00})
      `SC_OFS_CONTROL: rd_word = control_word32;
      `SC_OFS_ADVERT: rd_word = advert_word; // R11
      `SC_OFS_SPECIAL: rd_word = {22'h000000, addr0_unique_reg, 9'h000};
      `SC_OFS_STRAP: rd_word = {16'h0000, (state_reg == strap_config_pkg::ST_RUN),
                                mode_reserved(strap_reg.mode), strap_reg, `SC_ADDR_UPPER_RESET};
      `SC_OFS_PINOUT: rd_word = {20'h00000, pinout_reg};
      `SC_OFS_RX_COUNT: rd_word = 32'(rx_count_reg);
      `SC_OFS_TX_COUNT: rd_word = 32'(tx_count_reg);
      default: begin
        rd_word = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read channel: one read under way, answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `SC_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? `SC_RESP_OKAY : `SC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end else begin
        s_axi_arready <= !s_axi_rvalid;
      end
    end
  end

endmodule

`default_nettype wire

//--- src/strap_config_params.svh
// Purpose: Offsets, field positions, reset values and counts for the strap loader
// Assumes: 32-bit AXI4-Lite register words, byte addresses
// Notes: Definitions only
`ifndef STRAP_CONFIG_PARAMS_SVH
`define STRAP_CONFIG_PARAMS_SVH

// Register byte offsets
`define SC_OFS_CONTROL 6'h00
`define SC_OFS_ADVERT 6'h04
`define SC_OFS_SPECIAL 6'h08
`define SC_OFS_STRAP 6'h0c
`define SC_OFS_PINOUT 6'h10
`define SC_OFS_RX_COUNT 6'h14
`define SC_OFS_TX_COUNT 6'h18

// Control register fields
`define SC_CTL_DUPLEX 8
`define SC_CTL_ISOLATE 10
`define SC_CTL_AUTONEG 12
`define SC_CTL_SPEED 13
// Advertisement fields: 10 Mbps half/full, 100 Mbps half/full
`define SC_ADV_10_HALF 5
`define SC_ADV_10_FULL 6
`define SC_ADV_100_HALF 7
`define SC_ADV_100_FULL 8
// Special control field: address zero treated as unique
`define SC_SPC_ADDR0_UNIQUE 9

// Strap pin count and pin positions on the strap bus
`define SC_STRAP_PINS 12
`define SC_PIN_ADDR_LO 0
`define SC_PIN_MODE_LO 3
`define SC_PIN_ISOLATE 6
`define SC_PIN_SPEED 7
`define SC_PIN_DUPLEX 8
`define SC_PIN_AUTONEG 9
`define SC_PIN_ADDR0_UNIQUE 10
`define SC_PIN_TEST_N 11

// Interface-select codes
`define SC_MODE_RMII 3'h0
`define SC_MODE_B2B 3'h6

// Upper station-address bits after reset
`define SC_ADDR_UPPER_RESET 2'h0

// AXI responses
`define SC_RESP_OKAY 2'h0
`define SC_RESP_SLVERR 2'h2

`endif

//--- src/strap_config_pkg.sv
// Purpose: Types shared by the strap loader and its bench
// Assumes: Nothing beyond the params header
// Notes: Types only
package strap_config_pkg;

  // Capture sequence states
  typedef enum logic [0:0] {
    ST_CAPTURE,
    ST_RUN
  } cap_state_t;

  // Decoded strap image
  typedef struct packed {
    logic test_mode_en;
    logic addr0_unique;
    logic autoneg_en;
    logic duplex_full;
    logic speed_100;
    logic isolate;
    logic [2:0] mode;
    logic [2:0] addr_lo;
  } strap_image_t;

  // One RMII dibit beat
  typedef struct packed {
    logic valid;
    logic [1:0] dibit;
  } dibit_beat_t;

endpackage

//--- tb/rmii_mac_model.sv
// Purpose: Behavioural MAC on the RMII side
// Assumes: Shares the bench clock as reference timing
// Notes: Sends a counted frame of dibits, counts received dibits
`timescale 1ns/100ps
`default_nettype none
module rmii_mac_model (
  input wire logic aclk,
  input wire logic start,
  input wire logic [7:0] beats,
  input wire logic rmii_crs_dv,
  input wire logic [1:0] rmii_rxd,
  output logic rmii_tx_en = 1'h0,
  output logic [1:0] rmii_txd = 2'h0,
  output logic [15:0] rx_n = 16'h0,
  output logic [15:0] rx_sum = 16'h0
);
  logic [7:0] left = 8'h0;
  // One dibit per cycle while the frame lasts; data toggles outside frames
  always @(posedge aclk) begin
    if (start) left <= beats;
    else if (left != 8'h0) left <= left - 8'h01;
    rmii_tx_en <= !start && left != 8'h0;
    rmii_txd <= (!start && left != 8'h0) ? left[1:0] : ~rmii_txd;
  end
  // Count every received beat and sum its data
  always @(posedge aclk) begin
    if (rmii_crs_dv === 1'h1) begin
      rx_n <= rx_n + 16'h1;
      rx_sum <= rx_sum + {14'h0, rmii_rxd};
    end
  end
endmodule
`default_nettype wire

//--- tb/strap_config_latch_bench.sv
// Purpose: Self-checking bench for the strap loader
// Assumes: AXI4-Lite master tasks, MAC model on RMII
// Notes: Pads read back the device drive once it owns them
`include "strap_config_params.svh"
`timescale 1ns/100ps
`default_nettype none
module strap_config_latch_bench;
  logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [5:0] s_axi_awaddr = 6'h0, s_axi_araddr = 6'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [11:0] strap_val = 12'hb81, strap_pad_out, strap_pad_oe_n;
  wire logic [11:0] strap_pad_in;
  logic [4:0] mgmt_addr = 5'h0, station_address;
  logic mgmt_addr_hit, interface_mode_reserved, test_mode_en, rmii_crs_dv, tx_data_valid, rmii_tx_en;
  logic [2:0] interface_mode;
  logic [15:0] control_word, mac_rx_n, mac_rx_sum;
  logic rx_data_valid = 1'h0, mac_start = 1'h0;
  logic [1:0] rx_data = 2'h0, rmii_rxd, tx_data, rmii_txd;
  logic [7:0] mac_beats = 8'h0;
  int n_errors = 0, n_compared = 0, tx_n = 0, tx_sum = 0;
  // Pad level: strap pulls while released, device drive once enabled
  assign strap_pad_in = (strap_val & strap_pad_oe_n) | (strap_pad_out & ~strap_pad_oe_n);
  strap_config_latch #(.COUNT_W(16)) i_dut (.*);
  rmii_mac_model i_mac (.aclk(aclk), .start(mac_start), .beats(mac_beats), .rmii_crs_dv(rmii_crs_dv),
    .rmii_rxd(rmii_rxd), .rmii_tx_en(rmii_tx_en), .rmii_txd(rmii_txd), .rx_n(mac_rx_n), .rx_sum(mac_rx_sum));
  initial forever #25 aclk = ~aclk;
  // Count transmit beats handed inward
  always @(posedge aclk) begin
    if (tx_data_valid === 1'h1) begin
      tx_n <= tx_n + 1;
      tx_sum <= tx_sum + int'(tx_data);
    end
  end
  task automatic end_sim();
    if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic hang();
    chk("handshake", 32'h0, 32'h1);
    end_sim();
  endtask
  task automatic axi_wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    if (i == 50) hang();
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd_chk(input string nm, input logic [5:0] a, input logic [31:0] m, input logic [31:0] e,
      input logic [1:0] er);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    if (i == 50) hang();
    chk(nm, s_axi_rdata & m, e);
    chk(nm, {30'h0, s_axi_rresp}, {30'h0, er});
    s_axi_rready <= 1'h0;
  endtask
  task automatic do_reset(input logic [11:0] v);
    @(posedge aclk);
    strap_val <= v;
    aresetn <= 1'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (4) @(posedge aclk);
  endtask
  task automatic rx_burst(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      rx_data_valid <= 1'h1;
      rx_data <= i[1:0];
    end
    @(posedge aclk);
    rx_data_valid <= 1'h0;
    rx_data <= ~rx_data;
    repeat (3) @(posedge aclk);
  endtask
  // Settings expected from a strap vector
  task automatic cfg_chk(input logic [11:0] v);
    logic [2:0] m;
    m = v[5:3];
    chk("station", station_address, {2'h0, v[2:0]});
    chk("mode", interface_mode, m);
    chk("reserved", interface_mode_reserved, !(m == 3'h0 || m == 3'h6));
    chk("test", test_mode_en, !v[11]);
    chk("isolate", control_word[`SC_CTL_ISOLATE], v[6]);
    chk("speed", control_word[`SC_CTL_SPEED], v[7]);
    chk("duplex", control_word[`SC_CTL_DUPLEX], !v[8]);
    chk("autoneg", control_word[`SC_CTL_AUTONEG], v[9]);
    chk("hit0", mgmt_addr_hit, v[2:0] == 3'h0 || !v[10]);
    rd_chk("advert", `SC_OFS_ADVERT, 32'h180, {23'h0, v[7], v[7], 7'h0}, `SC_RESP_OKAY);
    rd_chk("special", `SC_OFS_SPECIAL, 32'h200, {22'h0, v[10], 9'h0}, `SC_RESP_OKAY);
  endtask
  task automatic t_straps();
    for (int c = 0; c < 8; c++) begin
      do_reset({6'h2e, c[2:0], c[2:0]});
      cfg_chk({6'h2e, c[2:0], c[2:0]});
    end
  endtask
  task automatic t_hold();
    logic [1:0] r;
    do_reset(12'h476);
    cfg_chk(12'h476);
    rx_burst(4);
    chk("iso rx", mac_rx_n, 32'h0);
    axi_wr(`SC_OFS_PINOUT, 32'hb89, r);
    repeat (3) @(posedge aclk);
    chk("oe", strap_pad_oe_n, 32'h0);
    chk("pads", strap_pad_in, 32'hb89);
    cfg_chk(12'h476);
  endtask
  task automatic t_sw();
    logic [1:0] r;
    do_reset(12'hb81);
    mgmt_addr <= 5'h03;
    repeat (3) @(posedge aclk);
    chk("hit other", mgmt_addr_hit, 32'h0);
    mgmt_addr <= 5'h01;
    repeat (3) @(posedge aclk);
    chk("hit own", mgmt_addr_hit, 32'h1);
    mgmt_addr <= 5'h00;
    axi_wr(`SC_OFS_SPECIAL, 32'h200, r);
    repeat (3) @(posedge aclk);
    chk("hit0 sw", mgmt_addr_hit, 32'h0);
    chk("wr resp", r, `SC_RESP_OKAY);
    axi_wr(`SC_OFS_CONTROL, 32'h0400, r);
    rx_burst(2);
    chk("sw ctl", control_word, 32'h0400);
    chk("sw iso rx", mac_rx_n, 32'h0);
    axi_wr(`SC_OFS_STRAP, 32'h0, r);
    chk("ro resp", r, `SC_RESP_SLVERR);
    rd_chk("strap st", `SC_OFS_STRAP, 32'hffff, 32'h8a04, `SC_RESP_OKAY);
    rd_chk("unmapped", 6'h1c, 32'hffffffff, 32'h0, `SC_RESP_SLVERR);
  endtask
  task automatic t_rmii();
    do_reset(12'hb81);
    rx_burst(5);
    @(posedge aclk);
    mac_beats <= 8'h06;
    mac_start <= 1'h1;
    @(posedge aclk);
    mac_start <= 1'h0;
    repeat (10) @(posedge aclk);
    chk("rx n", mac_rx_n, 32'h5);
    chk("rx sum", mac_rx_sum, 32'h6);
    chk("tx n", tx_n, 32'h6);
    chk("tx sum", tx_sum, 32'h9);
    rd_chk("rx cnt", `SC_OFS_RX_COUNT, 32'hffff, 32'h5, `SC_RESP_OKAY);
    rd_chk("tx cnt", `SC_OFS_TX_COUNT, 32'hffff, 32'h6, `SC_RESP_OKAY);
    ce <= 1'h0;
    rx_burst(3);
    ce <= 1'h1;
    chk("ce rx", mac_rx_n, 32'h5);
    rd_chk("ce cnt", `SC_OFS_RX_COUNT, 32'hffff, 32'h5, `SC_RESP_OKAY);
  endtask
  initial begin
    t_straps();
    t_hold();
    t_sw();
    t_rmii();
    end_sim();
  end
endmodule
`default_nettype wire

//--- tb/strap_config_latch_sva.sv
// Purpose: Port-level assertions for the strap loader
// Assumes: Only top-level ports are visible
// Notes: Bound onto the design at the foot of this file
`include "strap_config_params.svh"
`timescale 1ns/100ps
`default_nettype none
module strap_config_latch_sva #(
  parameter int COUNT_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [`SC_STRAP_PINS-1:0] strap_pad_oe_n,
  input wire logic [4:0] mgmt_addr,
  input wire logic mgmt_addr_hit,
  input wire logic [4:0] station_address,
  input wire logic [2:0] interface_mode,
  input wire logic interface_mode_reserved,
  input wire logic test_mode_en,
  input wire logic [15:0] control_word,
  input wire logic rx_data_valid,
  input wire logic [1:0] rx_data,
  input wire logic rmii_crs_dv,
  input wire logic [1:0] rmii_rxd,
  input wire logic rmii_tx_en,
  input wire logic [1:0] rmii_txd,
  input wire logic tx_data_valid,
  input wire logic [1:0] tx_data
);
  logic run;
  logic iso;
  // Running means pads handed over and clock enabled
  assign run = ce && (strap_pad_oe_n == '0);
  assign iso = control_word[`SC_CTL_ISOLATE];
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Release on an enabled edge followed by one more enabled edge
  sequence s_release;
    $rose(aresetn) && ce ##1 ce;
  endsequence
  property p_release;
    s_release |-> &strap_pad_oe_n ##1 (strap_pad_oe_n == '0);
  endproperty
  property p_rx;
    run && rx_data_valid && !iso |=> rmii_crs_dv && rmii_rxd == $past(rx_data);
  endproperty
  property p_tx;
    run && rmii_tx_en && !iso |=> tx_data_valid && tx_data == $past(rmii_txd);
  endproperty
  property p_iso;
    ce && iso |=> !rmii_crs_dv && !tx_data_valid;
  endproperty
  property p_hold;
    run && $past(run) |-> $stable({station_address, interface_mode, interface_mode_reserved, test_mode_en});
  endproperty
  property p_upper;
    run |-> station_address[4:3] == `SC_ADDR_UPPER_RESET;
  endproperty
  property p_mode;
    run |-> interface_mode_reserved == !(interface_mode == `SC_MODE_RMII || interface_mode == `SC_MODE_B2B);
  endproperty
  property p_hit;
    run && mgmt_addr == station_address |=> mgmt_addr_hit;
  endproperty
  property p_miss;
    run && mgmt_addr != station_address && mgmt_addr != 5'h00 |=> !mgmt_addr_hit;
  endproperty
  a_release: assert property (p_release) else $error("pads not handed over after release");
  a_rx: assert property (p_rx) else $error("receive dibit not passed");
  a_tx: assert property (p_tx) else $error("transmit dibit not taken");
  a_iso: assert property (p_iso) else $error("data moved while isolated");
  a_hold: assert property (p_hold) else $error("captured strap value changed");
  a_upper: assert property (p_upper) else $error("upper address bits not zero");
  a_mode: assert property (p_mode) else $error("reserved mode flag wrong");
  a_hit: assert property (p_hit) else $error("own address not matched");
  a_miss: assert property (p_miss) else $error("foreign address matched");
endmodule
bind strap_config_latch strap_config_latch_sva #(.COUNT_W(COUNT_W)) i_sva (.*);
`default_nettype wire
